// File: logic/emdl_top.sv
// Emitter driver settings, modulation and delay-lock sequencer with Avalon-MM registers.
`include "emdl_cfg.svh"

module emdl_top
  import emdl_pkg::*;
(
  input wire logic clk_i, // 125 MHz clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic ce_i, // clock enable, freezes all state when low
  input wire logic [5:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall request
  input wire logic frame_req_i, // pulse, a frame is about to start
  input wire logic frame_active_i, // level, frame acquisition running
  input wire logic demod_ref_i, // demodulation phase from pixel path
  input wire logic emitter_feedback_in_i, // feedback pin
  output logic frame_go_o, // pulse, frame may start
  output logic sync_busy_o, // level, synchronization running
  output logic demod_o, // demodulation drive
  output logic [3:0] demod_delay_sel_o, // demodulation delay select
  output logic [13:0] delay_code_o, // compensation delay line code
  output logic dll_en_o, // loop enabled
  output emdl_drv_s drv_o // emitter driver controls
);
  localparam int HALF_MIN = `EMDL_HALF_MIN;
  localparam logic [13:0] DLY_MAX = 14'(`EMDL_DLY_STEPS);
  localparam logic [6:0] US_LAST = 7'(`EMDL_CYC_PER_US - 1);

  function automatic logic [9:0] avg_count(input int base, input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > `EMDL_SEL_MAX) ? `EMDL_SEL_MAX : sel;
    avg_count = 10'(1 << (base + int'(s)));
  endfunction : avg_count

  function automatic logic [13:0] clamp_code(input logic signed [17:0] v);
    if (v < 0) begin
      clamp_code = 14'h0000;
    end else if (v > $signed({4'h0, DLY_MAX})) begin
      clamp_code = DLY_MAX;
    end else begin
      clamp_code = v[13:0];
    end
  endfunction : clamp_code

  emdl_ctrl_s ctrl;
  logic [7:0] rate;
  logic [15:0] pre_us;
  logic [15:0] lock_us;
  logic [3:0] demod_sel;
  logic [2:0] s1_sel;
  logic [2:0] s2_sel;
  logic [7:0] half;
  emdl_state_e state;
  logic [7:0] frame_cnt;
  logic [6:0] us_div;
  logic [15:0] us_cnt;
  logic [7:0] sq_cnt;
  logic sq;
  logic ack;
  logic fb_m, fb_s, ref_m, ref_s, ref_d;
  logic [9:0] p_cnt;
  logic signed [10:0] net;
  logic signed [15:0] pend;
  logic [9:0] f_cnt;
  logic [13:0] code;
  logic misconf;
  logic od_q;
  logic us_tick, phase_end, cmp_evt, s1_done, wb_fire, mod_run, level;
  logic [7:0] half_eff;
  logic [31:0] next_rdata;

  // Avalon slave: every access waits exactly one cycle.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack <= 1'b0;
    end else if (ce_i) begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (avs_address)
      `EMDL_REG_CTRL: next_rdata = {25'h0, ctrl};
      `EMDL_REG_RATE: next_rdata = {24'h0, rate};
      `EMDL_REG_PRE: next_rdata = {16'h0, pre_us};
      `EMDL_REG_LOCK: next_rdata = {16'h0, lock_us};
      `EMDL_REG_DEMOD: next_rdata = {28'h0, demod_sel};
      `EMDL_REG_FILT: next_rdata = {25'h0, s2_sel, 1'b0, s1_sel};
      `EMDL_REG_HALF: next_rdata = {24'h0, half};
      `EMDL_REG_STAT: next_rdata = {11'h0, misconf, 1'b0, state, 2'h0, code};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce_i && avs_read && !ack) begin
      avs_readdata <= next_rdata;
    end
  end

  // Settings are applied at once; keeping them still during a frame is up to software.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl <= emdl_ctrl_s'(`EMDL_CTRL_RST); // R5 R6
      rate <= 8'h00;
      pre_us <= `EMDL_PRE_US; // R13
      lock_us <= `EMDL_LOCK_US; // R13
      demod_sel <= `EMDL_DEMOD_RST;
      s1_sel <= 3'h0;
      s2_sel <= 3'h0;
      half <= `EMDL_HALF_RST;
    end else if (ce_i && avs_write && ack) begin
      unique case (avs_address)
        `EMDL_REG_CTRL: ctrl <= emdl_ctrl_s'(avs_writedata[6:0]);
        `EMDL_REG_RATE: rate <= avs_writedata[7:0];
        `EMDL_REG_PRE: pre_us <= avs_writedata[15:0];
        `EMDL_REG_LOCK: lock_us <= avs_writedata[15:0];
        `EMDL_REG_DEMOD: demod_sel <= avs_writedata[3:0];
        `EMDL_REG_FILT: begin
          s1_sel <= avs_writedata[2:0];
          s2_sel <= avs_writedata[6:4];
        end
        `EMDL_REG_HALF: half <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // Pin inputs pass two flip-flops; the reference passes a third, read with the second for edge detection.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      fb_m <= 1'b0;
      fb_s <= 1'b0;
      ref_m <= 1'b0;
      ref_s <= 1'b0;
      ref_d <= 1'b0;
    end else if (ce_i) begin
      fb_m <= emitter_feedback_in_i;
      fb_s <= fb_m;
      ref_m <= demod_ref_i;
      ref_s <= ref_m;
      ref_d <= ref_s;
    end
  end

  // Microsecond tick times the two synchronization phases.
  assign us_tick = (us_div == US_LAST);
  assign phase_end = us_tick && (us_cnt + 16'd1 >= ((state == EMDL_ST_PRE) ? pre_us : lock_us));
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      us_div <= 7'h00;
      us_cnt <= 16'h0000;
    end else if (ce_i) begin
      if (state == EMDL_ST_IDLE || phase_end) begin
        us_div <= 7'h00;
        us_cnt <= 16'h0000;
      end else if (us_tick) begin
        us_div <= 7'h00;
        us_cnt <= us_cnt + 16'd1; // R13
      end else begin
        us_div <= us_div + 7'd1;
      end
    end
  end

  // Sequencer: every rate-th frame runs pre-sync then lock before the frame goes.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= EMDL_ST_IDLE;
      frame_cnt <= 8'h00;
      frame_go_o <= 1'b0;
    end else if (ce_i) begin
      frame_go_o <= 1'b0;
      unique case (state)
        EMDL_ST_IDLE: begin
          if (frame_req_i) begin
            if (rate == 8'h00) begin
              frame_go_o <= 1'b1; // R10
            end else begin
              frame_cnt <= (frame_cnt + 8'd1 >= rate) ? 8'h00 : frame_cnt + 8'd1; // R9
              if (frame_cnt == 8'h00) begin
                state <= EMDL_ST_PRE; // R9 R12
              end else begin
                frame_go_o <= 1'b1;
              end
            end
          end
        end
        EMDL_ST_PRE: begin
          if (phase_end) begin
            state <= EMDL_ST_LOCK; // R12
          end
        end
        EMDL_ST_LOCK: begin
          if (phase_end) begin
            state <= EMDL_ST_IDLE; // R15
            frame_go_o <= 1'b1;
          end
        end
      endcase
    end
  end

  // Square-wave modulation; the half period never drops below the 20 MHz limit.
  assign half_eff = (int'(half) < HALF_MIN) ? 8'(HALF_MIN) : half; // R8
  assign mod_run = (state != EMDL_ST_IDLE) || frame_active_i;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sq_cnt <= 8'h00;
      sq <= 1'b0;
    end else if (ce_i) begin
      if (!mod_run) begin
        sq_cnt <= 8'h00;
        sq <= 1'b0;
      end else if (sq_cnt + 8'd1 >= half_eff) begin
        sq_cnt <= 8'h00;
        sq <= ~sq; // R8 R12
      end else begin
        sq_cnt <= sq_cnt + 8'd1;
      end
    end
  end

  // Phase detector: feedback already high at the reference edge means it leads.
  assign cmp_evt = (state == EMDL_ST_LOCK) && ref_s && !ref_d; // R14
  assign s1_done = cmp_evt && (p_cnt + 10'd1 >= avg_count(`EMDL_S1_BASE, s1_sel)); // R20
  assign wb_fire = (state == EMDL_ST_LOCK) && phase_end &&
                   (f_cnt >= avg_count(`EMDL_S2_BASE, s2_sel)); // R21 R22
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      p_cnt <= 10'h000;
      net <= 11'sh000;
      pend <= 16'sh0000;
    end else if (ce_i) begin
      if (wb_fire) begin
        p_cnt <= 10'h000;
        net <= 11'sh000;
        pend <= 16'sh0000;
      end else if (s1_done) begin
        p_cnt <= 10'h000;
        net <= 11'sh000;
        if (net + (fb_s ? 11'sh001 : -11'sh001) > 0) begin
          pend <= pend + 16'sh0001; // R23
        end else if (net + (fb_s ? 11'sh001 : -11'sh001) < 0) begin
          pend <= pend - 16'sh0001; // R23
        end
      end else if (cmp_evt) begin
        p_cnt <= p_cnt + 10'd1;
        net <= fb_s ? net + 11'sh001 : net - 11'sh001; // R23
      end
    end
  end

  // Frame counter of the second filter stage.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      f_cnt <= 10'h000;
    end else if (ce_i) begin
      if (wb_fire) begin
        f_cnt <= 10'h000;
      end else if (frame_req_i && f_cnt != 10'h3FF) begin
        f_cnt <= f_cnt + 10'd1; // R21
      end
    end
  end

  // Code 0 is the 6 ns minimum the line always inserts; it only moves at write-back.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      code <= 14'h0000;
    end else if (ce_i && wb_fire) begin
      code <= clamp_code(18'(signed'({4'h0, code})) + 18'(pend)); // R14 R17 R22
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      misconf <= 1'b0;
    end else if (ce_i) begin
      misconf <= (state == EMDL_ST_LOCK) && (demod_sel == 4'h0); // R18
    end
  end

  // Output stage: torch overrides modulation, inversion acts on both pins.
  assign level = (ctrl.torch | sq) ^ ctrl.inv; // R4 R6
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      drv_o <= '0;
      od_q <= 1'b0;
      demod_o <= 1'b0;
    end else if (ce_i) begin
      drv_o.pushpull_emitter_out <= ctrl.pp_en & level; // R2 R6
      drv_o.od_on <= ctrl.drv_en & level; // R4 R5
      od_q <= ctrl.drv_en & level;
      drv_o.od_aux <= ctrl.slew ? od_q : (ctrl.drv_en & level); // R7
      drv_o.cur_sel <= ctrl.cur_sel; // R3
      demod_o <= sq;
    end
  end

  assign sync_busy_o = (state != EMDL_ST_IDLE);
  assign dll_en_o = (state == EMDL_ST_LOCK); // R12
  assign delay_code_o = code;
  assign demod_delay_sel_o = demod_sel;

  sequence seq_req_sync;
    ce_i && state == EMDL_ST_IDLE && frame_req_i && rate != 8'h00 && frame_cnt == 8'h00;
  endsequence
  sequence seq_enter_pre;
    ##1 state == EMDL_ST_PRE;
  endsequence

  AST_TORCH: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
    ce_i && ctrl.torch && ctrl.drv_en && !ctrl.inv |=> drv_o.od_on)
    else $error("torch did not hold emitter on");
  AST_RESET_DEF: assert property (@(posedge clk_i) // R5 R6
    !rst_b_i |=> ctrl.drv_en && !ctrl.inv && !ctrl.torch)
    else $error("driver defaults wrong after reset");
  AST_INVERT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R6
    ce_i && ctrl.inv && ctrl.drv_en && !ctrl.torch && !sq |=> drv_o.od_on)
    else $error("inversion not applied");
  AST_SLEW: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
    ce_i && ctrl.slew && $rose(drv_o.od_on) |-> !drv_o.od_aux)
    else $error("slew part switched without delay");
  AST_SKIP: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
    ce_i && state == EMDL_ST_IDLE && frame_req_i && rate == 8'h00 |=>
      frame_go_o && state == EMDL_ST_IDLE)
    else $error("sync not skipped at rate zero");
  AST_SYNC_START: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
    seq_req_sync |-> seq_enter_pre)
    else $error("due sync did not start");
  AST_PHASE_ORDER: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
    state == EMDL_ST_IDLE |=> state != EMDL_ST_LOCK)
    else $error("lock entered without pre-sync");
  AST_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R15
    state != EMDL_ST_LOCK |=> $stable(code))
    else $error("delay changed outside lock");
  AST_WB_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R22
    !$stable(code) |-> $past(wb_fire))
    else $error("delay written without count reached");
  AST_RANGE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R17
    code <= DLY_MAX)
    else $error("delay code out of range");
  AST_VOTE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R23
    ce_i && cmp_evt && !s1_done && !wb_fire && fb_s |=> net == $past(net) + 11'sh001)
    else $error("leading feedback did not step up");
  AST_HALF: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
    ce_i && mod_run && sq_cnt + 8'd1 < half_eff |=> $stable(sq) || !ce_i || !$past(mod_run))
    else $error("square wave edge too early");
endmodule : emdl_top

// File: logic/emdl_cfg.svh
// Constants for the emitter modulation and delay-lock block.
//
// Contract
// (R1) Software keeps emitter driver settings unchanged during a frame acquisition.
// (R2) Only one emitter output in use; open-drain driver may be disabled.
// (R3) Current select scales open-drain maximum to 100, 64, 46 or 33 percent.
// (R4) Torch bit holds the emitter output permanently active.
// (R5) Driver enable gates the driver circuits; set after reset.
// (R6) Inversion bit inverts both emitter outputs; cleared after reset.
// (R7) Slew control switches part of the driver on with a delay.
// (R8) Modulating modes carry a 50 percent square wave of at most 20 MHz.
// (R9) A synchronization period precedes acquisition once every N frames.
// (R10) Rate zero skips synchronization and keeps the last compensation delay.
// (R11) Software sets demodulation delay select to at least 1 before locking.
// (R12) Sync has pre-synchronization with loop off, then lock with loop on.
// (R13) Pre-sync defaults to 10 us, lock to 30 us; both programmable.
// (R14) Loop compares reference phase with feedback and adds emitter delay.
// (R15) Compensation delay is frozen until the next synchronization period.
// (R16) Software sets the rate to a multiple of the frame count.
// (R17) Delay line spans 6 ns to 76 ns in 7 ps steps.
// (R18) Loop enabled inserts at least 6 ns; demodulation delay select stays nonzero. Code only flags a zero select in misconf during lock.
// (R19) Software raises demodulation delay select above 1 for wide feedback drift.
// (R20) First filter averages over 8 to 512 pulses in binary steps.
// (R21) Second filter averages over 2 to 128 frames in binary steps.
// (R22) Averaged values are written back only when programmed counts are reached.
// (R23) Phase detector steps delay up when feedback leads, down when it lags.
`ifndef EMDL_CFG_SVH
`define EMDL_CFG_SVH
`define EMDL_CLK_PS 8000
`define EMDL_CYC_PER_US (1000000 / `EMDL_CLK_PS)
`define EMDL_PRE_US 16'd10
`define EMDL_LOCK_US 16'd30
`define EMDL_DLY_MIN_PS 6000
`define EMDL_DLY_MAX_PS 76000
`define EMDL_DLY_STEP_PS 7
`define EMDL_DLY_STEPS ((`EMDL_DLY_MAX_PS - `EMDL_DLY_MIN_PS) / `EMDL_DLY_STEP_PS)
`define EMDL_MOD_MAX_HZ 20000000
`define EMDL_CLK_HZ ((1000000000 / `EMDL_CLK_PS) * 1000)
`define EMDL_HALF_MIN ((`EMDL_CLK_HZ + 2 * `EMDL_MOD_MAX_HZ - 1) / (2 * `EMDL_MOD_MAX_HZ))
`define EMDL_REG_CTRL 6'h00
`define EMDL_REG_RATE 6'h04
`define EMDL_REG_PRE 6'h08
`define EMDL_REG_LOCK 6'h0C
`define EMDL_REG_DEMOD 6'h10
`define EMDL_REG_FILT 6'h14
`define EMDL_REG_HALF 6'h18
`define EMDL_REG_STAT 6'h1C
`define EMDL_CTRL_RST 7'h01
`define EMDL_DEMOD_RST 4'h1
`define EMDL_HALF_RST 8'h04
`define EMDL_S1_BASE 3
`define EMDL_S2_BASE 1
`define EMDL_SEL_MAX 3'd6
`endif

// File: logic/emdl_pkg.sv
// Types shared by the emitter modulation and delay-lock block.
package emdl_pkg;
  typedef enum logic [2:0] {
    EMDL_ST_IDLE = 3'b001,
    EMDL_ST_PRE = 3'b010,
    EMDL_ST_LOCK = 3'b100
  } emdl_state_e;

  typedef struct packed {
    logic [1:0] cur_sel;
    logic torch;
    logic slew;
    logic inv;
    logic pp_en;
    logic drv_en;
  } emdl_ctrl_s;

  typedef struct packed {
    logic pushpull_emitter_out;
    logic od_on;
    logic od_aux;
    logic [1:0] cur_sel;
  } emdl_drv_s;
endpackage : emdl_pkg

// File: dv/emdl_emitter_model.sv
// Behavioural emitter circuit with a delayed feedback path and the pixel return path.
module emdl_emitter_model
  import emdl_pkg::*;
(
  input wire logic clk_i, // modulation clock
  input wire emdl_drv_s drv_i, // emitter driver controls
  input wire logic demod_i, // demodulation drive
  input wire logic lead_i, // high makes feedback lead the reference
  output logic feedback_o, // feedback pin level
  output logic ref_o // demodulation phase back from the pixels
);
  logic [3:0] fb_pipe = 4'h0;
  logic [1:0] ref_pipe = 2'h0;
  // Both emitter outputs drive the one emitter and may be on together, so the two lines are ORed here.
  // Feedback drift stays within one clock period, so delay select 1 is kept.
  always_ff @(posedge clk_i) begin
    fb_pipe <= {fb_pipe[2:0], drv_i.od_on | drv_i.pushpull_emitter_out};
    ref_pipe <= {ref_pipe[0], demod_i};
  end
  // One cycle of lead or lag against the two-cycle pixel path.
  assign feedback_o = lead_i ? fb_pipe[0] : fb_pipe[2];
  assign ref_o = ref_pipe[1];
endmodule : emdl_emitter_model

// File: dv/tb.sv
// Self-checking testbench for the emitter modulation and delay-lock block.
`include "emdl_cfg.svh"

module tb;
  import emdl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic rst_b_i;
  logic ce_i;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic frame_req_i;
  logic frame_active_i;
  logic demod_ref_i;
  logic emitter_feedback_in_i;
  logic frame_go_o;
  logic sync_busy_o;
  logic demod_o;
  logic [3:0] demod_delay_sel_o;
  logic [13:0] delay_code_o;
  logic dll_en_o;
  emdl_drv_s drv_o;
  logic lead;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;

  emdl_top u_emdl_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_req_i(frame_req_i),
    .frame_active_i(frame_active_i), .demod_ref_i(demod_ref_i),
    .emitter_feedback_in_i(emitter_feedback_in_i), .frame_go_o(frame_go_o),
    .sync_busy_o(sync_busy_o), .demod_o(demod_o), .demod_delay_sel_o(demod_delay_sel_o),
    .delay_code_o(delay_code_o), .dll_en_o(dll_en_o), .drv_o(drv_o));

  emdl_emitter_model u_emdl_emitter_model (.clk_i(clk_i), .drv_i(drv_o), .demod_i(demod_o),
    .lead_i(lead), .feedback_o(emitter_feedback_in_i), .ref_o(demod_ref_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // The ceiling leaves ample room over the fewer than 3000 cycles the tests need.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waitrequest is sampled at the rising edge; the access completes at the edge where it is low.
  task bus_wr(input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask : bus_wr

  task bus_rd(input logic [5:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_i);
  endtask : bus_rd

  task rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask : rd_chk

  task do_reset;
    rst_b_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset

  // Counts pre-sync cycles, lock cycles and total cycles until the frame is released.
  task frame(output int pre_n, output int lock_n, output int go_n);
    pre_n = 0;
    lock_n = 0;
    go_n = 0;
    frame_req_i <= 1'b1;
    @(posedge clk_i);
    frame_req_i <= 1'b0;
    @(negedge clk_i);
    while (frame_go_o !== 1'b1 && go_n < 3000) begin
      if (sync_busy_o === 1'b1 && dll_en_o === 1'b0) pre_n++;
      if (dll_en_o === 1'b1) lock_n++;
      go_n++;
      @(negedge clk_i);
    end
    if (go_n >= 3000) n_mismatch++;
    @(posedge clk_i);
  endtask : frame

  task measure(input logic sl, output int hi, output int lo);
    logic prev;
    int k;
    hi = 0;
    lo = 0;
    k = 0;
    while (drv_o.od_on !== 1'b0 && k < 50) begin @(negedge clk_i); k++; end
    while (drv_o.od_on !== 1'b1 && k < 100) begin @(negedge clk_i); k++; end
    while (drv_o.od_on === 1'b1 && hi < 300) begin
      prev = drv_o.od_on;
      @(negedge clk_i);
      hi++;
      if (sl) chk(drv_o.od_aux, prev);
    end
    while (drv_o.od_on === 1'b0 && lo < 300) begin
      prev = drv_o.od_on;
      @(negedge clk_i);
      lo++;
      if (sl) chk(drv_o.od_aux, prev);
    end
    @(posedge clk_i);
  endtask : measure

  task t_regs;
    rd_chk(`EMDL_REG_CTRL, 32'h00000001);
    rd_chk(`EMDL_REG_RATE, 32'h00000000);
    rd_chk(`EMDL_REG_PRE, 32'h0000000A);
    rd_chk(`EMDL_REG_LOCK, 32'h0000001E);
    rd_chk(`EMDL_REG_DEMOD, 32'h00000001);
    chk(demod_delay_sel_o, 32'h00000001);
    rd_chk(`EMDL_REG_FILT, 32'h00000000);
    rd_chk(`EMDL_REG_HALF, 32'h00000004);
    rd_chk(`EMDL_REG_STAT, 32'h00010000);
    bus_wr(6'h20, 32'hFFFFFFFF);
    rd_chk(6'h20, 32'h00000000);
  endtask : t_regs

  task t_rate0;
    int p, l, g;
    logic [13:0] c0;
    c0 = delay_code_o;
    frame(p, l, g);
    chk(g, 0);
    chk(p + l, 0);
    chk(delay_code_o, c0);
  endtask : t_rate0

  task t_sync;
    int p, l, g;
    bus_wr(`EMDL_REG_PRE, 32'h00000001);
    bus_wr(`EMDL_REG_LOCK, 32'h00000001);
    bus_wr(`EMDL_REG_RATE, 32'h00000002);
    rd_chk(`EMDL_REG_PRE, 32'h00000001);
    frame(p, l, g);
    chk(p, 125);
    chk(l, 125);
    frame(p, l, g);
    chk(g, 0);
    frame(p, l, g);
    chk(g, 250);
  endtask : t_sync

  task t_lock;
    int p, l, g, k;
    logic [13:0] c0, c1;
    bus_wr(`EMDL_REG_PRE, 32'h00000001);
    bus_wr(`EMDL_REG_LOCK, 32'h00000001);
    bus_wr(`EMDL_REG_RATE, 32'h00000001);
    lead <= 1'b1;
    c0 = delay_code_o;
    for (k = 0; k < 4; k++) frame(p, l, g);
    c1 = delay_code_o;
    chk(c1 > c0, 1);
    repeat (50) @(posedge clk_i);
    chk(delay_code_o, c1);
    lead <= 1'b0;
    for (k = 0; k < 4; k++) frame(p, l, g);
    chk(delay_code_o < c1, 1);
  endtask : t_lock

  // Settings are only changed while no frame is active.
  task t_drv;
    int k;
    for (k = 0; k < 4; k++) begin
      bus_wr(`EMDL_REG_CTRL, {25'h0, k[1:0], 5'h01});
      repeat (3) @(posedge clk_i);
      chk(drv_o.cur_sel, k[1:0]);
    end
    bus_wr(`EMDL_REG_CTRL, 32'h00000011);
    repeat (20) @(posedge clk_i);
    chk(drv_o.od_on, 1'b1);
    bus_wr(`EMDL_REG_CTRL, 32'h00000015);
    repeat (3) @(posedge clk_i);
    chk(drv_o.od_on, 1'b0);
    bus_wr(`EMDL_REG_CTRL, 32'h00000013);
    repeat (3) @(posedge clk_i);
    chk(drv_o.pushpull_emitter_out, 1'b1);
    bus_wr(`EMDL_REG_CTRL, 32'h00000017);
    repeat (3) @(posedge clk_i);
    chk(drv_o.pushpull_emitter_out, 1'b0);
    bus_wr(`EMDL_REG_CTRL, 32'h00000010);
    repeat (3) @(posedge clk_i);
    chk(drv_o.od_on, 1'b0);
  endtask : t_drv

  task t_mod;
    int hi, lo;
    emdl_drv_s d0;
    bus_wr(`EMDL_REG_CTRL, 32'h00000009);
    frame_active_i <= 1'b1;
    @(posedge clk_i);
    measure(1'b1, hi, lo);
    chk(hi, 4);
    chk(lo, 4);
    // With the clock enable low the running square wave must freeze.
    ce_i <= 1'b0;
    @(posedge clk_i);
    d0 = drv_o;
    repeat (10) @(posedge clk_i);
    chk(drv_o, d0);
    ce_i <= 1'b1;
    frame_active_i <= 1'b0;
    bus_wr(`EMDL_REG_HALF, 32'h00000002);
    frame_active_i <= 1'b1;
    @(posedge clk_i);
    measure(1'b0, hi, lo);
    chk(hi, 4);
    chk(lo, 4);
    frame_active_i <= 1'b0;
  endtask : t_mod

  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    frame_req_i = 1'b0;
    frame_active_i = 1'b0;
    lead = 1'b1;
    do_reset();
    t_regs();
    t_rate0();
    t_drv();
    t_mod();
    do_reset();
    t_sync();
    do_reset();
    t_lock();
    summarize();
  end
endmodule : tb
